/* test/ivm_core_props.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Port-level checks of the vector mapper
// ----------------------------------------------------------------------------
module ivm_core_props (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        watchdog_window_req,
   input wire logic        watchdog_indep_req,
   input wire logic        dma_ch2_req,
   input wire logic        dma_ch3_req,
   input wire logic        vec_rd_r,
   input wire logic        vec_rvalid,
   input wire logic [31:0] vec_addr_r,
   input wire logic        main_stack_pointer_valid_r,
   input wire logic        service_routine_valid_r,
   input wire logic [5:0]  service_routine_vec_r,
   input wire logic [2:0]  active_level_r,
   input wire logic        nmi_req_r,
   input wire logic [31:0] irq_line_r
);
   // One clock domain, so clocking and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_nmi_quiet: assert property (
      !nmi_req_r) else $error("nmi request raised");
   a_boot_order: assert property (
      !main_stack_pointer_valid_r && vec_rd_r |-> vec_addr_r == 32'h0000_0000)
      else $error("first fetch not from slot zero");
   a_read_holds: assert property (
      vec_rd_r && !(ce && vec_rvalid) |=> vec_rd_r && $stable(vec_addr_r))
      else $error("fetch dropped before data");
   a_after_read: assert property (
      service_routine_valid_r |-> $past(vec_rd_r && vec_rvalid && ce)
         || $past(service_routine_valid_r && !ce))
      else $error("handler given without a table read");
   a_slot_addr: assert property (
      service_routine_valid_r |-> $past(vec_addr_r) == {24'h00_0000, service_routine_vec_r, 2'h0})
      else $error("fetch address is not slot times four");
   a_no_reserved: assert property (
      service_routine_valid_r |-> !(service_routine_vec_r inside
         {6'h00, 6'h02, [6'h04:6'h0A], 6'h0C, 6'h0D, 6'h23}))
      else $error("reserved slot delivered");
   a_fixed_level: assert property (
      service_routine_valid_r && service_routine_vec_r == 6'h03 |-> active_level_r == 3'h2)
      else $error("hard error urgency wrong");
   a_cfg_level: assert property (
      service_routine_valid_r && service_routine_vec_r >= 6'h0B |->
         active_level_r inside {[3'h3:3'h6]}) else $error("settable urgency out of range");
   a_line_or: assert property (
      ce |=> irq_line_r[0] == $past(watchdog_window_req || watchdog_indep_req)
         && irq_line_r[10] == $past(dma_ch2_req || dma_ch3_req))
      else $error("shared line is not the OR of its sources");
   a_line_spare: assert property (
      irq_line_r[19] == 1'b0) else $error("unused line raised");
endmodule

bind ivm_core ivm_core_props u_ivm_core_props (
   .clk, .rst, .ce, .watchdog_window_req, .watchdog_indep_req, .dma_ch2_req, .dma_ch3_req,
   .vec_rd_r, .vec_rvalid, .vec_addr_r, .main_stack_pointer_valid_r, .service_routine_valid_r,
   .service_routine_vec_r, .active_level_r, .nmi_req_r, .irq_line_r
);

/* test/ivm_vec_table.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Vector table memory answering the mapper's fetches
// ----------------------------------------------------------------------------
module ivm_vec_table (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        vec_rd_r,
   input  wire logic [31:0] vec_addr_r,
   input  wire logic [3:0]  wait_cycles,
   output      logic        vec_rvalid,
   output      logic [31:0] vec_rdata
);
   logic [3:0] wait_r;

   // Slot zero holds the stack start, every other slot a handler entry
   function automatic logic [31:0] slot_word(input logic [5:0] slot);
      slot_word = (slot == 6'h00) ? 32'h2000_0FF0 : {18'h0_0000, slot, 8'h01};
   endfunction

   // One word per request, indexed by byte address over four; data is
   // inverted every idle cycle so a stale word can never pass as fresh
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vec_rvalid <= 1'b0;
         vec_rdata  <= 32'hFFFF_FFFF;
         wait_r     <= 4'h0;
      end else if (vec_rd_r && !vec_rvalid && wait_r >= wait_cycles) begin
         vec_rvalid <= 1'b1;
         vec_rdata  <= slot_word(vec_addr_r[7:2]);
         wait_r     <= 4'h0;
      end else begin
         vec_rvalid <= 1'b0;
         vec_rdata  <= ~vec_rdata;
         wait_r     <= (vec_rd_r && !vec_rvalid) ? wait_r + 4'h1 : 4'h0;
      end
   end
endmodule

/* test/tb.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Self-checking bench for the vector mapper
// ----------------------------------------------------------------------------
module tb;
   logic        clk           = 1'b0;
   logic        rst           = 1'b1;
   logic        ce            = 1'b1;
   logic [42:0] src           = '0;
   logic [3:0]  exc           = 4'h0;
   logic        prio_wr       = 1'b0;
   logic [5:0]  prio_wr_vec   = 6'h00;
   logic [1:0]  prio_wr_level = 2'h0;
   logic        handler_done  = 1'b0;
   logic [3:0]  wait_cycles   = 4'h0;
   logic        vec_rvalid, vec_rd_r, main_stack_pointer_valid_r, service_routine_valid_r;
   logic        nmi_req_r;
   logic [31:0] vec_rdata, vec_addr_r, main_stack_pointer_r, service_routine_r, irq_line_r;
   logic [5:0]  service_routine_vec_r;
   logic [2:0]  active_level_r;
   int          miscompares   = 0;
   int          n_compared    = 0;
   // Rows: source index beside the line it must reach
   int          line_of [43]  = '{0, 0, 1, 2, 3, 3, 4, 4, 4, 4, 4, 4, 5, 6, 7, 7, 8, 9, 10, 10,
                                  11, 12, 13, 14, 15, 16, 17, 18, 20, 21, 21, 22, 23, 24, 25,
                                  26, 27, 28, 29, 30, 30, 31, 31};
   logic [5:0]  exc_slot [4]  = '{6'h0B, 6'h0E, 6'h0F, 6'h03};
   logic [2:0]  exc_lvl [4]   = '{3'h3, 3'h3, 3'h3, 3'h2};

   // 250 MHz clock
   always #2 clk = ~clk;

   ivm_core u_ivm_core (
      .clk(clk), .rst(rst), .ce(ce), .watchdog_window_req(src[0]), .watchdog_indep_req(src[1]),
      .low_voltage_detect_request(src[2]), .rtc_req(src[3]), .flash_ctrl_req(src[4]),
      .ram_ctrl_req(src[5]), .fast_external_crystal_start_fail(src[6]),
      .slow_external_crystal_start_fail(src[7]), .slow_internal_oscillator_stable(src[8]),
      .slow_external_crystal_stable(src[9]), .fast_internal_oscillator_stable(src[10]),
      .fast_external_crystal_stable(src[11]), .gpio_a_req(src[12]), .gpio_b_req(src[13]),
      .gpio_c_req(src[14]), .gpio_d_req(src[15]), .gpio_f_req(src[16]), .dma_ch1_req(src[17]),
      .dma_ch2_req(src[18]), .dma_ch3_req(src[19]), .dma_ch4_req(src[20]), .adc_req(src[21]),
      .advanced_timer_request(src[22]), .voltage_comparator_one_request(src[23]),
      .voltage_comparator_two_request(src[24]), .general_timer_one_request(src[25]),
      .general_timer_two_request(src[26]), .general_timer_three_request(src[27]),
      .basic_timer_one_request(src[28]), .basic_timer_two_request(src[29]),
      .low_power_timer_request(src[30]), .basic_timer_three_request(src[31]),
      .i2c_one_req(src[32]), .i2c_two_req(src[33]), .spi_one_req(src[34]), .spi_two_req(src[35]),
      .uart_one_req(src[36]), .uart_two_req(src[37]), .uart_three_req(src[38]),
      .oscillator_trim_request(src[39]), .lcd_req(src[40]),
      .fast_external_crystal_run_fail(src[41]), .slow_external_crystal_run_fail(src[42]),
      .supervisor_call_exception(exc[0]), .pendable_service_request(exc[1]),
      .system_tick_exception(exc[2]), .hard_error_exception(exc[3]), .prio_wr(prio_wr),
      .prio_wr_vec(prio_wr_vec), .prio_wr_level(prio_wr_level), .handler_done(handler_done),
      .vec_rvalid(vec_rvalid), .vec_rdata(vec_rdata), .vec_rd_r(vec_rd_r),
      .vec_addr_r(vec_addr_r), .main_stack_pointer_r(main_stack_pointer_r),
      .main_stack_pointer_valid_r(main_stack_pointer_valid_r),
      .service_routine_r(service_routine_r), .service_routine_valid_r(service_routine_valid_r),
      .service_routine_vec_r(service_routine_vec_r), .active_level_r(active_level_r),
      .nmi_req_r(nmi_req_r), .irq_line_r(irq_line_r)
   );

   ivm_vec_table u_ivm_vec_table (
      .clk(clk), .rst(rst), .vec_rd_r(vec_rd_r), .vec_addr_r(vec_addr_r),
      .wait_cycles(wait_cycles), .vec_rvalid(vec_rvalid), .vec_rdata(vec_rdata)
   );

   // Expected table word, kept apart from the memory model's own copy
   function automatic logic [31:0] exp_word(input logic [5:0] slot);
      exp_word = (slot == 6'h00) ? 32'h2000_0FF0 : {18'h0_0000, slot, 8'h01};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits a bounded time for a handler delivery, then checks it
   task automatic take(input logic [5:0] slot, input logic [2:0] lvl);
      int n;
      n = 0;
      while (service_routine_valid_r !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk(32'(service_routine_valid_r), 32'h1);
      chk(32'(service_routine_vec_r), 32'(slot));
      chk(service_routine_r, exp_word(slot));
      chk(32'(active_level_r), 32'(lvl));
      @(negedge clk);
   endtask

   // Handler return; the gap lets the cleared source leave its line first
   task automatic ret();
      repeat (2) @(negedge clk);
      handler_done = 1'b1;
      @(negedge clk);
      handler_done = 1'b0;
   endtask

   task automatic set_prio(input logic [5:0] slot, input logic [1:0] lvl);
      prio_wr       = 1'b1;
      prio_wr_vec   = slot;
      prio_wr_level = lvl;
      @(negedge clk);
      prio_wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic do_reset();
      rst = 1'b1;
      repeat (10) @(negedge clk);
      chk(32'(vec_rd_r), 32'h1);
      chk(vec_addr_r, 32'h0000_0000);
      chk(32'(active_level_r), 32'h7);
      chk(32'(nmi_req_r), 32'h0);
      chk(32'(main_stack_pointer_valid_r), 32'h0);
      rst = 1'b0;
      take(6'h01, 3'h7);
      chk(main_stack_pointer_r, exp_word(6'h00));
      chk(32'(main_stack_pointer_valid_r), 32'h1);
   endtask

   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Watchdog: the whole sequence needs some 600 cycles
   initial begin
      #40000;
      miscompares++;
      test_done();
   end

   // Main sequence: row loop first, then the awkward cases
   initial begin
      do_reset();
      for (int i = 0; i < 43; i++) begin
         src[i] = 1'b1;
         take(6'(line_of[i] + 16), 3'h3);
         chk(irq_line_r, 32'h1 << line_of[i]);
         src[i] = 1'b0;
         ret();
         repeat (3) @(negedge clk);
         chk(32'(active_level_r), 32'h7);
      end
      for (int i = 0; i < 4; i++) begin
         exc[i] = 1'b1;
         @(negedge clk);
         exc[i] = 1'b0;
         take(exc_slot[i], exc_lvl[i]);
         ret();
      end
      // Equal urgency: lowest line first, the other waits for the return
      src[37:36] = 2'h3;
      take(6'h2B, 3'h3);
      repeat (10) @(negedge clk);
      chk(32'(service_routine_vec_r), 32'h2B);
      src[36] = 1'b0;
      ret();
      take(6'h2C, 3'h3);
      src[37] = 1'b0;
      ret();
      // Settable levels, strict preemption, then hard error above all
      set_prio(6'h2C, 2'h3);
      set_prio(6'h2D, 2'h1);
      src[37] = 1'b1;
      take(6'h2C, 3'h6);
      src[38] = 1'b1;
      take(6'h2D, 3'h4);
      exc[3] = 1'b1;
      @(negedge clk);
      exc[3] = 1'b0;
      take(6'h03, 3'h2);
      src[38:37] = 2'h0;
      repeat (3) ret();
      repeat (3) @(negedge clk);
      chk(32'(active_level_r), 32'h7);
      // Second reset with a slow table; urgencies must be back at zero
      wait_cycles = 4'h3;
      do_reset();
      // Enable low: the raised source must not reach its line until enable returns
      ce = 1'b0;
      src[37] = 1'b1;
      repeat (5) @(negedge clk);
      chk(irq_line_r, 32'h0);
      chk(32'(active_level_r), 32'h7);
      ce = 1'b1;
      take(6'h2C, 3'h3);
      src[37] = 1'b0;
      ret();
      test_done();
   end
endmodule

/* verilog/ivm_core.sv */
`timescale 1ns/10ps
module ivm_core
   import ivm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Peripheral request sources, levels held until software clears them
   input  wire logic        watchdog_window_req,
   input  wire logic        watchdog_indep_req,
   input  wire logic        low_voltage_detect_request,
   input  wire logic        rtc_req,
   input  wire logic        flash_ctrl_req,
   input  wire logic        ram_ctrl_req,
   input  wire logic        fast_external_crystal_start_fail,
   input  wire logic        slow_external_crystal_start_fail,
   input  wire logic        slow_internal_oscillator_stable,
   input  wire logic        slow_external_crystal_stable,
   input  wire logic        fast_internal_oscillator_stable,
   input  wire logic        fast_external_crystal_stable,
   input  wire logic        gpio_a_req,
   input  wire logic        gpio_b_req,
   input  wire logic        gpio_c_req,
   input  wire logic        gpio_d_req,
   input  wire logic        gpio_f_req,
   input  wire logic        dma_ch1_req,
   input  wire logic        dma_ch2_req,
   input  wire logic        dma_ch3_req,
   input  wire logic        dma_ch4_req,
   input  wire logic        adc_req,
   input  wire logic        advanced_timer_request,
   input  wire logic        voltage_comparator_one_request,
   input  wire logic        voltage_comparator_two_request,
   input  wire logic        general_timer_one_request,
   input  wire logic        general_timer_two_request,
   input  wire logic        general_timer_three_request,
   input  wire logic        basic_timer_one_request,
   input  wire logic        basic_timer_two_request,
   input  wire logic        low_power_timer_request,
   input  wire logic        basic_timer_three_request,
   input  wire logic        i2c_one_req,
   input  wire logic        i2c_two_req,
   input  wire logic        spi_one_req,
   input  wire logic        spi_two_req,
   input  wire logic        uart_one_req,
   input  wire logic        uart_two_req,
   input  wire logic        uart_three_req,
   input  wire logic        oscillator_trim_request,
   input  wire logic        lcd_req,
   input  wire logic        fast_external_crystal_run_fail,
   input  wire logic        slow_external_crystal_run_fail,
   // Core exception requests, one-cycle pulses
   input  wire logic        hard_error_exception,
   input  wire logic        supervisor_call_exception,
   input  wire logic        pendable_service_request,
   input  wire logic        system_tick_exception,
   // Urgency setting port
   input  wire logic        prio_wr,
   input  wire logic [5:0]  prio_wr_vec,
   input  wire logic [1:0]  prio_wr_level,
   // Handler return, one-cycle pulse
   input  wire logic        handler_done,
   // Vector table read port
   input  wire logic        vec_rvalid,
   input  wire logic [31:0] vec_rdata,
   output      logic        vec_rd_r,
   output      logic [31:0] vec_addr_r,
   // Results towards the core
   output      logic [31:0] main_stack_pointer_r,
   output      logic        main_stack_pointer_valid_r,
   output      logic [31:0] service_routine_r,
   output      logic        service_routine_valid_r,
   output      logic [5:0]  service_routine_vec_r,
   output      logic [2:0]  active_level_r,
   output      logic        nmi_req_r,
   output      logic [31:0] irq_line_r
);
   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      ivm_state_e                      st;
      logic [LINE_COUNT-1:0]           line;
      logic                            pend_hard;
      logic                            pend_svc;
      logic                            pend_pendable_service_request;
      logic                            pend_tick;
      logic [VEC_COUNT-1:0][1:0]       prio;
      logic [STACK_DEPTH-1:0][2:0]     stk;
      logic [SP_W-1:0]                 sp;
      logic                            rd;
      logic [31:0]                     addr;
      logic [5:0]                      fvec;
      logic [2:0]                      flvl;
      logic [31:0]                     main_stack_pointer;
      logic                            msp_valid;
      logic [31:0]                     handler;
      logic                            hvalid;
      logic [5:0]                      hvec;
      logic [2:0]                      act;
      logic                            nmi;
   } ivm_state_s;

   ivm_state_s                  s_r;
   ivm_state_s                  s_nxt;
   logic [LINE_COUNT-1:0]       raw_line;
   logic [VEC_COUNT-1:0][2:0]   cand_lvl;
   logic [5:0]                  win_vec;
   logic [2:0]                  win_lvl;
   logic [2:0]                  cur_lvl;

   // -------------------------------------------------------------------------
   // Source to line mapping
   // -------------------------------------------------------------------------
   // Shared lines OR their sources; software must poll flags to tell them apart
   always_comb begin
      raw_line      = '0;
      raw_line[0]   = watchdog_window_req | watchdog_indep_req;
      raw_line[1]   = low_voltage_detect_request;
      raw_line[2]   = rtc_req;
      raw_line[3]   = flash_ctrl_req | ram_ctrl_req;
      raw_line[4]   = fast_external_crystal_start_fail
                      | slow_external_crystal_start_fail
                      | slow_internal_oscillator_stable
                      | slow_external_crystal_stable
                      | fast_internal_oscillator_stable
                      | fast_external_crystal_stable;
      raw_line[5]   = gpio_a_req;
      raw_line[6]   = gpio_b_req;
      raw_line[7]   = gpio_c_req | gpio_d_req;
      raw_line[8]   = gpio_f_req;
      raw_line[9]   = dma_ch1_req;
      raw_line[10]  = dma_ch2_req | dma_ch3_req;
      raw_line[11]  = dma_ch4_req;
      raw_line[12]  = adc_req;
      raw_line[13]  = advanced_timer_request;
      raw_line[14]  = voltage_comparator_one_request;
      raw_line[15]  = voltage_comparator_two_request;
      raw_line[16]  = general_timer_one_request;
      raw_line[17]  = general_timer_two_request;
      raw_line[18]  = general_timer_three_request;
      raw_line[LINE_RESERVED] = 1'b0;
      raw_line[20]  = basic_timer_one_request;
      raw_line[21]  = basic_timer_two_request | low_power_timer_request;
      raw_line[22]  = basic_timer_three_request;
      raw_line[23]  = i2c_one_req;
      raw_line[24]  = i2c_two_req;
      raw_line[25]  = spi_one_req;
      raw_line[26]  = spi_two_req;
      raw_line[27]  = uart_one_req;
      raw_line[28]  = uart_two_req;
      raw_line[29]  = uart_three_req;
      raw_line[30]  = oscillator_trim_request | lcd_req;
      raw_line[31]  = fast_external_crystal_run_fail
                      | slow_external_crystal_run_fail;
   end

   // -------------------------------------------------------------------------
   // Candidate urgencies per slot
   // -------------------------------------------------------------------------
   // Fixed slots carry codes below every settable level, so nothing outranks them
   always_comb begin
      cand_lvl = '{default: LVL_NONE};
      for (int i = 0; i < LINE_COUNT; i++) begin
         if (s_r.line[i]) begin
            cand_lvl[i + VEC_COUNT - LINE_COUNT] =
               LVL_CFG_BASE + {1'b0, s_r.prio[i + VEC_COUNT - LINE_COUNT]};
         end
      end
      if (s_r.pend_hard) begin
         cand_lvl[VEC_HARD] = LVL_HARD;
      end
      if (s_r.pend_svc) begin
         cand_lvl[VEC_SVC] = LVL_CFG_BASE + {1'b0, s_r.prio[VEC_SVC]};
      end
      if (s_r.pend_pendable_service_request) begin
         cand_lvl[VEC_PENDABLE_SERVICE_REQUEST] = LVL_CFG_BASE + {1'b0, s_r.prio[VEC_PENDABLE_SERVICE_REQUEST]};
      end
      if (s_r.pend_tick) begin
         cand_lvl[VEC_SYSTEM_TICK_EXCEPTION] = LVL_CFG_BASE + {1'b0, s_r.prio[VEC_SYSTEM_TICK_EXCEPTION]};
      end
   end

   // Lowest slot wins among equals
   ivm_arbiter u_arb (
      .cand_lvl (cand_lvl),
      .win_vec  (win_vec),
      .win_lvl  (win_lvl)
   );

   // Urgency of whatever runs now; none when the stack is empty
   assign cur_lvl = s_r.act;

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      logic [SP_W-1:0] sp_v;
      logic            clr_hard;
      logic            clr_svc;
      logic            clr_pendable_service_request;
      logic            clr_tick;
      sp_v       = s_r.sp;
      clr_hard   = 1'b0;
      clr_svc    = 1'b0;
      clr_pendable_service_request = 1'b0;
      clr_tick   = 1'b0;
      s_nxt           = s_r;
      s_nxt.hvalid    = 1'b0;
      s_nxt.nmi       = 1'b0;
      s_nxt.line      = raw_line;

      // Settable urgencies only land on slots that allow it
      if (prio_wr && ivm_is_cfg(prio_wr_vec)) begin
         s_nxt.prio[prio_wr_vec] = prio_wr_level;
      end

      // Return from a handler pops one nesting level
      if (handler_done && (sp_v != '0)) begin
         sp_v = sp_v - 4'h1;
      end

      unique case (s_r.st)
         ST_BOOT_SP: begin
            if (vec_rvalid) begin
               s_nxt.main_stack_pointer       = vec_rdata;
               s_nxt.msp_valid = 1'b1;
               s_nxt.addr      = ivm_vec_addr(VEC_RESET);
               s_nxt.st        = ST_BOOT_RST;
            end
         end
         ST_BOOT_RST: begin
            if (vec_rvalid) begin
               s_nxt.rd      = 1'b0;
               s_nxt.handler = vec_rdata;
               s_nxt.hvalid  = 1'b1;
               s_nxt.hvec    = VEC_RESET;
               s_nxt.st      = ST_IDLE;
            end
         end
         ST_IDLE: begin
            // Only a strictly more urgent request preempts
            if (win_lvl < cur_lvl) begin
               s_nxt.rd   = 1'b1;
               s_nxt.addr = ivm_vec_addr(win_vec);
               s_nxt.fvec = win_vec;
               s_nxt.flvl = win_lvl;
               s_nxt.st   = ST_FETCH;
            end
         end
         ST_FETCH: begin
            // Handler address comes from the table before entry
            if (vec_rvalid) begin
               s_nxt.rd      = 1'b0;
               s_nxt.handler = vec_rdata;
               s_nxt.hvalid  = 1'b1;
               s_nxt.hvec    = s_r.fvec;
               s_nxt.stk[sp_v[2:0]] = s_r.flvl;
               sp_v          = sp_v + 4'h1;
               clr_hard      = (s_r.fvec == VEC_HARD);
               clr_svc       = (s_r.fvec == VEC_SVC);
               clr_pendable_service_request    = (s_r.fvec == VEC_PENDABLE_SERVICE_REQUEST);
               clr_tick      = (s_r.fvec == VEC_SYSTEM_TICK_EXCEPTION);
               s_nxt.st      = ST_IDLE;
            end
         end
      endcase

      // A new pulse in the clearing cycle is kept
      s_nxt.pend_hard   = (s_r.pend_hard & ~clr_hard) | hard_error_exception;
      s_nxt.pend_svc    = (s_r.pend_svc & ~clr_svc) | supervisor_call_exception;
      s_nxt.pend_pendable_service_request = (s_r.pend_pendable_service_request & ~clr_pendable_service_request) | pendable_service_request;
      s_nxt.pend_tick   = (s_r.pend_tick & ~clr_tick) | system_tick_exception;

      s_nxt.sp  = sp_v;
      s_nxt.act = (sp_v == '0) ? LVL_NONE : s_nxt.stk[3'(sp_v - 4'h1)];
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   // Boot starts straight away with a stack pointer read from slot zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r           <= '0;
         s_r.st        <= ST_BOOT_SP;
         s_r.prio      <= '{default: PRIO_RESET};
         s_r.rd        <= 1'b1;
         s_r.addr      <= 32'h00000000;
         s_r.act       <= LVL_NONE;
         s_r.flvl      <= LVL_NONE;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign vec_rd_r                   = s_r.rd;
   assign vec_addr_r                 = s_r.addr;
   assign main_stack_pointer_r       = s_r.main_stack_pointer;
   assign main_stack_pointer_valid_r = s_r.msp_valid;
   assign service_routine_r          = s_r.handler;
   assign service_routine_valid_r    = s_r.hvalid;
   assign service_routine_vec_r      = s_r.hvec;
   assign active_level_r             = s_r.act;
   assign nmi_req_r                  = s_r.nmi;
   assign irq_line_r                 = s_r.line;
endmodule

/* verilog/ivm_pkg_arbiter.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Shared constants, types and helpers
// ----------------------------------------------------------------------------
package ivm_pkg;
   // Vector table geometry
   localparam int          VEC_COUNT     = 48;
   localparam int          VEC_W         = 6;
   localparam int          LINE_COUNT    = 32;
   localparam int          ADDR_W        = 32;
   localparam int          WORD_SHIFT    = 2;
   // Fixed vector slots
   localparam logic [5:0]  VEC_SP        = 6'h00;
   localparam logic [5:0]  VEC_RESET     = 6'h01;
   localparam logic [5:0]  VEC_NMI       = 6'h02;
   localparam logic [5:0]  VEC_HARD      = 6'h03;
   localparam logic [5:0]  VEC_SVC       = 6'h0B;
   localparam logic [5:0]  VEC_PENDABLE_SERVICE_REQUEST    = 6'h0E;
   localparam logic [5:0]  VEC_SYSTEM_TICK_EXCEPTION   = 6'h0F;
   localparam logic [5:0]  VEC_EXT_BASE  = 6'h10;
   localparam int          LINE_RESERVED = 19;
   // Internal urgency code: smaller is more urgent
   localparam logic [2:0]  LVL_RESET     = 3'h0;
   localparam logic [2:0]  LVL_NMI       = 3'h1;
   localparam logic [2:0]  LVL_HARD      = 3'h2;
   localparam logic [2:0]  LVL_CFG_BASE  = 3'h3;
   localparam logic [2:0]  LVL_NONE      = 3'h7;
   localparam logic [1:0]  PRIO_RESET    = 2'h0;
   // Nesting stack
   localparam int          STACK_DEPTH   = 8;
   localparam int          SP_W          = 4;

   typedef enum logic [1:0] {
      ST_BOOT_SP,
      ST_BOOT_RST,
      ST_IDLE,
      ST_FETCH
   } ivm_state_e;

   typedef logic [2:0] ivm_lvl_t;

   // Byte address of a vector slot: one word per slot from zero
   function automatic logic [31:0] ivm_vec_addr(input logic [5:0] vec);
      ivm_vec_addr = {24'h000000, vec, 2'h0};
   endfunction

   // Slots whose urgency software may set
   function automatic logic ivm_is_cfg(input logic [5:0] vec);
      ivm_is_cfg = (vec == VEC_SVC) || (vec == VEC_PENDABLE_SERVICE_REQUEST) || (vec == VEC_SYSTEM_TICK_EXCEPTION)
                   || ((vec >= VEC_EXT_BASE) && (vec < 6'(VEC_COUNT)));
   endfunction
endpackage

// ----------------------------------------------------------------------------
// Picks the most urgent candidate; lowest slot wins a tie
// ----------------------------------------------------------------------------
module ivm_arbiter
   import ivm_pkg::*;
(
   input  wire logic [VEC_COUNT-1:0][2:0] cand_lvl,
   output      logic [5:0]                win_vec,
   output      logic [2:0]                win_lvl
);
   // Strict less-than keeps the earlier (lower numbered) slot on a tie
   always_comb begin
      win_vec = VEC_SP;
      win_lvl = LVL_NONE;
      for (int i = 0; i < VEC_COUNT; i++) begin
         if (cand_lvl[i] < win_lvl) begin
            win_lvl = cand_lvl[i];
            win_vec = 6'(i);
         end
      end
   end
endmodule
